// >>> core/rcw_defs.svh
// Offsets, field positions, reset values and widths of the countdown timer.
// Assumes it is included by bare name; it needs no package import.
`ifndef RCW_DEFS_SVH
`define RCW_DEFS_SVH

// ==========================================================================
// Register offsets, byte addresses within the block.
`define RCW_OFF_CONTROL   6'h00
`define RCW_OFF_STATUS    6'h04
`define RCW_OFF_DIVISOR   6'h08
`define RCW_OFF_SLEEP     6'h0C
`define RCW_OFF_REMAIN    6'h10
`define RCW_OFF_IRQ_EN    6'h14
`define RCW_OFF_RAW       6'h18
`define RCW_OFF_ENABLED   6'h1C
`define RCW_OFF_CLEAR     6'h20
`define RCW_OFF_ACCESS    6'h24
`define RCW_OFF_TICKS     6'h30

// ==========================================================================
// Field positions.
`define RCW_CTRL_EN       0
`define RCW_CTRL_AUTO     1
`define RCW_CTRL_GO       2
`define RCW_STAT_EN       0
`define RCW_STAT_GATE     1
`define RCW_STAT_FREEZE   2
`define RCW_STAT_RUN      3
`define RCW_DONE_BIT      0

// ==========================================================================
// Widths and reset values.
`define RCW_DIV_W         16
`define RCW_SLEEP_W       24
`define RCW_AUTO_RST      1'b1
`define RCW_DIV_RST       16'h8000
`define RCW_GATE_RST      1'b1

`endif

// >>> core/rcw_pkg.sv
// Types shared by the countdown timer files.
// Assumes nothing of its surroundings.
package rcw_pkg;

  // ========================================================================
  // Command buffer word carried from the bus side to the core.
  typedef struct packed {
    logic        write;
    logic [5:0]  offset;
    logic [31:0] data;
  } rcw_cmd_s;

  // ========================================================================
  // Bus side sequencer states.
  typedef enum logic [1:0] {
    RCW_ST_IDLE = 2'b00,
    RCW_ST_READ = 2'b01
  } rcw_bus_state_e;

endpackage : rcw_pkg

// >>> core/rcw_sync.sv
// Two flip-flop level synchroniser, one per bit of a vector.
// Assumes the input is a level held long enough to be sampled.
`timescale 1ns/1ps
module rcw_sync #(
  parameter int         W       = 1,
  parameter logic [0:0] RST_VAL = 1'b0
) (
  input  wire logic         clk,   // Destination clock.
  input  wire logic         rst_n, // Asynchronous reset, active low.
  input  wire logic [W-1:0] d,     // Level from the other domain.
  output logic      [W-1:0] q      // Synchronised level.
);

  logic [W-1:0] meta_ff;
  logic [W-1:0] q_ff;

  // First stage is read only by the second stage.
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      meta_ff <= {W{RST_VAL}};
      q_ff    <= {W{RST_VAL}};
    end else begin
      meta_ff <= d;
      q_ff    <= meta_ff;
    end
  end

  assign q = q_ff;

endmodule : rcw_sync

// >>> core/rcw_timer.sv
// Countdown wake-up timer: bus side on sys_clk, core on the slow oscillator.
// Assumes an APB master on sys_clk and a free running slow oscillator clock.
`timescale 1ns/1ps
`include "rcw_defs.svh"

// Function
// - Countdown on slow clock raises wake-up
// - Wake line 12 gated by enable bit
// - Tick when pulse count reaches divisor
// - Divisor bits 15:0, reset 8000h
// - Enable bit 0; disabled means no counting
// - Auto launch bit starts on sleep write
// - Go bit starts countdown from sleep value
// - Go clears on zero write, expiry, load with auto off
// - Status bit 0 shows enable
// - Freeze bit delays sleep writes
// - Run bit shows actual counting
// - Status bit 1 mirrors clock gate control
// - Core, bus slave and crossing kept apart
// - Registers at their listed offsets
// - Reserved bits read as zero
// - Decrement per tick, interrupt at zero
// - Clear register bit 0 clears done
// - Access status low while command pending
// - Tick counter counts ticks, software writable
module rcw_timer
  import rcw_pkg::*;
#(
  parameter int ADDR_W = 12
) (
  input  wire logic              sys_clk,   // Bus clock, 40 MHz.
  input  wire logic              rst_n,     // Asynchronous reset.
  input  wire logic              osc_clk,   // Low speed oscillator clock.
  input  wire logic              psel,      // APB select.
  input  wire logic              penable,   // APB enable phase.
  input  wire logic              pwrite,    // APB write.
  input  wire logic [ADDR_W-1:0] paddr,     // APB byte address.
  input  wire logic [31:0]       pwdata,    // APB write data.
  output logic      [31:0]       prdata,    // APB read data.
  output logic                   pready,    // APB ready.
  output logic                   pslverr,   // APB error.
  input  wire logic              clk_gate,  // Timer clock gate control.
  output logic                   wake_irq   // Wake-up interrupt 12.
);

  // ========================================================================
  // Parameter check.
  if (ADDR_W < 7) begin : g_bad_addr
    $error("rcw_timer: ADDR_W must be at least 7");
  end

  // ========================================================================
  // Bus side: APB slave and command buffer, all on sys_clk.
  rcw_bus_state_e state_ff;
  rcw_cmd_s       cmd_ff;
  logic           req_tgl_ff;
  logic           ack_sync;
  logic           busy;
  logic [31:0]    prdata_ff;
  logic           pready_ff;
  logic           pslverr_ff;
  logic           access;
  logic           mapped;
  logic [5:0]     offs;
  logic [31:0]    core_rdata_ff;
  logic           req_seen_ff;

  assign access = psel & penable & ~pready_ff;
  assign offs   = paddr[5:0];
  assign busy   = req_tgl_ff ^ ack_sync;

  // Decode of the mapped word addresses; anything else answers with error.
  always_comb begin
    mapped = 1'b0;
    if (paddr[ADDR_W-1:6] == '0) begin
      case (offs)
        `RCW_OFF_CONTROL, `RCW_OFF_STATUS, `RCW_OFF_DIVISOR,
        `RCW_OFF_SLEEP, `RCW_OFF_REMAIN, `RCW_OFF_IRQ_EN,
        `RCW_OFF_RAW, `RCW_OFF_ENABLED, `RCW_OFF_CLEAR,
        `RCW_OFF_ACCESS, `RCW_OFF_TICKS: mapped = 1'b1;
        default: mapped = 1'b0;
      endcase
    end
  end

  // The acknowledge toggle comes back from the core domain.
  rcw_sync #(
    .W       (1),
    .RST_VAL (1'b0)
  ) u_ack_sync (
    .clk   (sys_clk),
    .rst_n (rst_n),
    .d     (req_seen_ff),
    .q     (ack_sync)
  );

  // Sequencer: one command in flight; a new one waits while busy, which
  // stretches the access phase instead of losing the command.
  always_ff @(posedge sys_clk or negedge rst_n) begin
    if (!rst_n) begin
      state_ff   <= RCW_ST_IDLE;
      cmd_ff     <= '0;
      req_tgl_ff <= 1'b0;
      prdata_ff  <= 32'h0000_0000;
      pready_ff  <= 1'b0;
      pslverr_ff <= 1'b0;
    end else begin
      pready_ff  <= 1'b0;
      pslverr_ff <= 1'b0;
      case (state_ff)
        RCW_ST_IDLE: begin
          if (access && !mapped) begin
            prdata_ff  <= 32'h0000_0000;
            pready_ff  <= 1'b1;
            pslverr_ff <= 1'b1;
          end else if (access && offs == `RCW_OFF_ACCESS) begin
            prdata_ff <= {31'h0, ~busy};
            pready_ff <= 1'b1;
          end else if (access && !busy) begin
            cmd_ff     <= '{write: pwrite, offset: offs, data: pwdata};
            req_tgl_ff <= ~req_tgl_ff;
            if (pwrite) begin
              pready_ff <= 1'b1;
            end else begin
              state_ff <= RCW_ST_READ;
            end
          end
        end
        RCW_ST_READ: begin
          if (!busy) begin
            prdata_ff <= core_rdata_ff;
            pready_ff <= 1'b1;
            state_ff  <= RCW_ST_IDLE;
          end
        end
        default: state_ff <= RCW_ST_IDLE;
      endcase
    end
  end

  assign prdata  = prdata_ff;
  assign pready  = pready_ff;
  assign pslverr = pslverr_ff;

  // ========================================================================
  // Core side: always-on timer on the slow oscillator clock.
  logic                    req_sync;
  logic                    gate_sync;
  logic                    en_ff;
  logic                    auto_ff;
  logic                    go_ff;
  logic [`RCW_DIV_W-1:0]   div_ff;
  logic [`RCW_DIV_W-1:0]   pulse_ff;
  logic [`RCW_DIV_W-1:0]   div_m1;
  logic [`RCW_SLEEP_W-1:0] load_ff;
  logic [`RCW_SLEEP_W-1:0] remain_ff;
  logic [`RCW_SLEEP_W-1:0] pend_val_ff;
  logic                    pend_ff;
  logic                    ien_ff;
  logic                    raw_ff;
  logic [31:0]             ticks_ff;
  logic                    wake_irq_ff;
  logic                    cmd_fire;
  logic                    wr_fire;
  logic [31:0]             wd;
  logic                    wr_ctrl;
  logic                    wr_sleep;
  logic                    tick;
  logic                    freeze;
  logic                    sleep_apply;
  logic [`RCW_SLEEP_W-1:0] sleep_val;
  logic                    expire;
  logic                    run;

  // Request toggle and the clock gate level enter the core domain.
  rcw_sync #(
    .W       (1),
    .RST_VAL (1'b0)
  ) u_req_sync (
    .clk   (osc_clk),
    .rst_n (rst_n),
    .d     (req_tgl_ff),
    .q     (req_sync)
  );

  rcw_sync #(
    .W       (1),
    .RST_VAL (`RCW_GATE_RST)
  ) u_gate_sync (
    .clk   (osc_clk),
    .rst_n (rst_n),
    .d     (clk_gate),
    .q     (gate_sync)
  );

  // The command word is stable while the toggles differ, so it is read
  // straight from the bus flops only in the firing cycle.
  assign cmd_fire = req_sync ^ req_seen_ff;
  assign wr_fire  = cmd_fire & cmd_ff.write;
  assign wd       = cmd_ff.data;
  assign wr_ctrl  = wr_fire & (cmd_ff.offset == `RCW_OFF_CONTROL);
  assign wr_sleep = wr_fire & (cmd_ff.offset == `RCW_OFF_SLEEP);

  // Divisor zero acts as one; freeze then drops so sleep writes still land.
  assign div_m1 = (div_ff == '0) ? '0 : div_ff - 1'b1;
  assign tick   = en_ff & (pulse_ff >= div_m1);
  assign freeze = tick & (div_m1 != '0);
  assign run    = en_ff & go_ff;

  // Sleep loads wait out the tick edge; a fresh write beats a held one.
  assign sleep_apply = (wr_sleep | pend_ff) & ~freeze;
  assign sleep_val   = wr_sleep ? wd[`RCW_SLEEP_W-1:0] : pend_val_ff;
  assign expire      = tick & go_ff & (remain_ff <= 1);

  // Handshake: completing a command flips the acknowledge toggle.
  always_ff @(posedge osc_clk or negedge rst_n) begin
    if (!rst_n) begin
      req_seen_ff <= 1'b0;
    end else begin
      req_seen_ff <= req_sync;
    end
  end

  // Control bits and divisor.
  always_ff @(posedge osc_clk or negedge rst_n) begin
    if (!rst_n) begin
      en_ff   <= 1'b0;
      auto_ff <= `RCW_AUTO_RST;
      div_ff  <= `RCW_DIV_RST;
      ien_ff  <= 1'b0;
    end else if (wr_fire) begin
      if (wr_ctrl) begin
        en_ff   <= wd[`RCW_CTRL_EN];
        auto_ff <= wd[`RCW_CTRL_AUTO];
      end
      if (cmd_ff.offset == `RCW_OFF_DIVISOR) begin
        div_ff <= wd[`RCW_DIV_W-1:0];
      end
      if (cmd_ff.offset == `RCW_OFF_IRQ_EN) begin
        ien_ff <= wd[`RCW_DONE_BIT];
      end
    end
  end

  // Pulse counter; held at zero while the timer is disabled.
  always_ff @(posedge osc_clk or negedge rst_n) begin
    if (!rst_n) begin
      pulse_ff <= '0;
    end else if (!en_ff || tick) begin
      pulse_ff <= '0;
    end else begin
      pulse_ff <= pulse_ff + 1'b1;
    end
  end

  // Stored sleep value and the write held back by freeze.
  always_ff @(posedge osc_clk or negedge rst_n) begin
    if (!rst_n) begin
      load_ff     <= '0;
      pend_ff     <= 1'b0;
      pend_val_ff <= '0;
    end else if (wr_sleep && freeze) begin
      pend_ff     <= 1'b1;
      pend_val_ff <= wd[`RCW_SLEEP_W-1:0];
    end else if (sleep_apply) begin
      pend_ff <= 1'b0;
      load_ff <= sleep_val;
    end
  end

  // Go bit: a control write wins, then a sleep load, then expiry.
  always_ff @(posedge osc_clk or negedge rst_n) begin
    if (!rst_n) begin
      go_ff <= 1'b0;
    end else if (wr_ctrl) begin
      go_ff <= wd[`RCW_CTRL_GO];
    end else if (sleep_apply) begin
      go_ff <= auto_ff;
    end else if (expire) begin
      go_ff <= 1'b0;
    end
  end

  // Remaining ticks; only a running timer decrements.
  always_ff @(posedge osc_clk or negedge rst_n) begin
    if (!rst_n) begin
      remain_ff <= '0;
    end else if (wr_ctrl && wd[`RCW_CTRL_GO]) begin
      remain_ff <= load_ff;
    end else if (sleep_apply && auto_ff) begin
      remain_ff <= sleep_val;
    end else if (expire) begin
      remain_ff <= '0;
    end else if (tick && go_ff) begin
      remain_ff <= remain_ff - 1'b1;
    end
  end

  // Sticky done flag; expiry beats a clear in the same cycle.
  always_ff @(posedge osc_clk or negedge rst_n) begin
    if (!rst_n) begin
      raw_ff <= 1'b0;
    end else if (expire) begin
      raw_ff <= 1'b1;
    end else if (wr_fire && cmd_ff.offset == `RCW_OFF_CLEAR &&
                 wd[`RCW_DONE_BIT]) begin
      raw_ff <= 1'b0;
    end
  end

  // Tick counter, advancing only on ticks while enabled, software writable.
  always_ff @(posedge osc_clk or negedge rst_n) begin
    if (!rst_n) begin
      ticks_ff <= 32'h0000_0000;
    end else if (wr_fire && cmd_ff.offset == `RCW_OFF_TICKS) begin
      ticks_ff <= wd;
    end else if (tick) begin
      ticks_ff <= ticks_ff + 32'h0000_0001;
    end
  end

  // Wake-up line from a flop, so it never glitches into the wake logic.
  always_ff @(posedge osc_clk or negedge rst_n) begin
    if (!rst_n) begin
      wake_irq_ff <= 1'b0;
    end else begin
      wake_irq_ff <= raw_ff & ien_ff;
    end
  end

  assign wake_irq = wake_irq_ff;

  // Read data captured once per read command; unused bits read zero.
  always_ff @(posedge osc_clk or negedge rst_n) begin
    if (!rst_n) begin
      core_rdata_ff <= 32'h0000_0000;
    end else if (cmd_fire && !cmd_ff.write) begin
      core_rdata_ff <= 32'h0000_0000;
      case (cmd_ff.offset)
        `RCW_OFF_CONTROL: core_rdata_ff[2:0] <= {go_ff, auto_ff, en_ff};
        `RCW_OFF_STATUS:  core_rdata_ff[3:0] <=
          {run, freeze, gate_sync, en_ff};
        `RCW_OFF_DIVISOR: core_rdata_ff[`RCW_DIV_W-1:0] <= div_ff;
        `RCW_OFF_SLEEP:   core_rdata_ff[`RCW_SLEEP_W-1:0] <= load_ff;
        `RCW_OFF_REMAIN:  core_rdata_ff[`RCW_SLEEP_W-1:0] <= remain_ff;
        `RCW_OFF_IRQ_EN:  core_rdata_ff[0] <= ien_ff;
        `RCW_OFF_RAW:     core_rdata_ff[0] <= raw_ff;
        `RCW_OFF_ENABLED: core_rdata_ff[0] <= raw_ff & ien_ff;
        `RCW_OFF_TICKS:   core_rdata_ff <= ticks_ff;
        default:          core_rdata_ff <= 32'h0000_0000;
      endcase
    end
  end

  // ========================================================================
  // Checks on the core domain.
  property p_irq_follow;
    @(posedge osc_clk) disable iff (!rst_n)
      (raw_ff && ien_ff) |=> wake_irq_ff;
  endproperty
  a_irq_follow: assert property (p_irq_follow)
    else $error("wake line did not follow enabled done");

  property p_irq_gated;
    @(posedge osc_clk) disable iff (!rst_n)
      !ien_ff |=> !wake_irq_ff;
  endproperty
  a_irq_gated: assert property (p_irq_gated)
    else $error("wake line raised while disabled");

  property p_no_tick_off;
    @(posedge osc_clk) disable iff (!rst_n)
      !en_ff && !cmd_fire |=> $stable(remain_ff) && $stable(ticks_ff);
  endproperty
  a_no_tick_off: assert property (p_no_tick_off)
    else $error("timer moved while disabled");

  property p_dec;
    @(posedge osc_clk) disable iff (!rst_n)
      tick && go_ff && remain_ff > 1 && !cmd_fire && !pend_ff
      |=> remain_ff == $past(remain_ff) - 1'b1;
  endproperty
  a_dec: assert property (p_dec)
    else $error("remaining count did not decrement");

  sequence s_expire;
    tick && go_ff && remain_ff == 1 && !cmd_fire && !pend_ff;
  endsequence
  sequence s_done;
    raw_ff && !go_ff && remain_ff == 0;
  endsequence
  property p_expire;
    @(posedge osc_clk) disable iff (!rst_n) s_expire |=> s_done;
  endproperty
  a_expire: assert property (p_expire)
    else $error("expiry did not flag done and stop");

  property p_sticky;
    @(posedge osc_clk) disable iff (!rst_n)
      raw_ff && !wr_fire |=> raw_ff;
  endproperty
  a_sticky: assert property (p_sticky)
    else $error("done flag dropped without a clear");

  property p_tick_count;
    @(posedge osc_clk) disable iff (!rst_n)
      tick && !wr_fire |=> ticks_ff == $past(ticks_ff) + 32'h0000_0001;
  endproperty
  a_tick_count: assert property (p_tick_count)
    else $error("tick counter missed a tick");

  property p_freeze_hold;
    @(posedge osc_clk) disable iff (!rst_n)
      wr_sleep && freeze |=> pend_ff && $stable(load_ff);
  endproperty
  a_freeze_hold: assert property (p_freeze_hold)
    else $error("sleep load not held during freeze");

  property p_auto_load;
    @(posedge osc_clk) disable iff (!rst_n)
      wr_sleep && !freeze && auto_ff
      |=> go_ff && remain_ff == $past(wd[`RCW_SLEEP_W-1:0]);
  endproperty
  a_auto_load: assert property (p_auto_load)
    else $error("sleep write did not auto launch");

  // Checks on the bus domain.
  sequence s_issue;
    req_tgl_ff != $past(req_tgl_ff);
  endsequence
  property p_pending;
    @(posedge sys_clk) disable iff (!rst_n) s_issue |-> busy;
  endproperty
  a_pending: assert property (p_pending)
    else $error("access status ready with command pending");

endmodule : rcw_timer

// >>> bench/rcw_apb_model.sv
// APB master model standing in for the processor on the register bus.
// Assumes a registered one-cycle pready from the timer on the same clock.
`timescale 1ns/1ps
module rcw_apb_model (
  input  wire logic        clk,     // Bus clock.
  input  wire logic        pready,  // Ready from the timer.
  input  wire logic        pslverr, // Error from the timer.
  input  wire logic [31:0] prdata,  // Read data from the timer.
  output logic             psel,    // Select.
  output logic             penable, // Enable phase.
  output logic             pwrite,  // Direction.
  output logic [11:0]      paddr,   // Byte address.
  output logic [31:0]      pwdata   // Write data.
);
  // ==========================================================================
  // Idle bus at time zero.
  initial begin
    psel = 1'b0;
    penable = 1'b0;
    pwrite = 1'b0;
    paddr = 12'h000;
    pwdata = 32'h0000_0000;
  end

  // One transfer; ready is looked at on the falling edge so that the rising
  // edge which samples it is never raced, then the bus is released.
  task automatic xfer(input logic wr, input logic [11:0] a,
                      input logic [31:0] d, output logic [31:0] rd,
                      output logic err, output logic ok);
    int i;
    @(posedge clk);
    #1;
    psel = 1'b1;
    pwrite = wr;
    paddr = a;
    pwdata = d;
    @(posedge clk);
    #1;
    penable = 1'b1;
    for (i = 0; i < 4000; i++) begin
      @(negedge clk);
      if (pready === 1'b1) break;
    end
    ok = (pready === 1'b1);
    rd = prdata;
    err = pslverr;
    @(posedge clk);
    #1;
    psel = 1'b0;
    penable = 1'b0;
    pwrite = ~wr;
    paddr = ~a;
    pwdata = ~d;
  endtask : xfer
endmodule : rcw_apb_model

// >>> bench/rtc_countdown_wakeup_timer_test.sv
// Self-checking bench for the countdown wake-up timer.
// Assumes the APB model file and the core files are compiled first.
`timescale 1ns/1ps
`include "rcw_defs.svh"
module rtc_countdown_wakeup_timer_test;
  logic        sys_clk  = 1'b0;
  logic        osc_clk  = 1'b0;
  logic        rst_n    = 1'b0;
  logic        clk_gate = 1'b1;
  logic        psel, penable, pwrite, pready, pslverr, wake_irq, err, ok;
  logic [11:0] paddr;
  logic [31:0] pwdata, prdata, rd, r;
  logic [31:0] seed = 32'h07A3CCAF;
  int          num_errors = 0;
  int          n_compared = 0;
  int          m_div, k, i;
  logic [11:0] offs [11] = '{12'h000, 12'h004, 12'h008, 12'h00C, 12'h010,
    12'h014, 12'h018, 12'h01C, 12'h020, 12'h024, 12'h030};
  logic [31:0] rstv [11] = '{32'h2, 32'h2, 32'h8000, 32'h0, 32'h0, 32'h0,
    32'h0, 32'h0, 32'h0, 32'h1, 32'h0};

  // ==========================================================================
  // Clocks: periods differ so the two domains drift in phase.
  always #12.5 sys_clk = ~sys_clk;
  always #15 osc_clk = ~osc_clk;

  rcw_timer #(.ADDR_W(12)) u_dut (.sys_clk(sys_clk), .rst_n(rst_n),
    .osc_clk(osc_clk), .psel(psel), .penable(penable), .pwrite(pwrite),
    .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
    .pslverr(pslverr), .clk_gate(clk_gate), .wake_irq(wake_irq));

  rcw_apb_model u_apb (.clk(sys_clk), .pready(pready), .pslverr(pslverr),
    .prdata(prdata), .psel(psel), .penable(penable), .pwrite(pwrite),
    .paddr(paddr), .pwdata(pwdata));

  // ==========================================================================
  // Helpers.
  function automatic logic [31:0] xs();
    seed ^= seed << 13;
    seed ^= seed >> 17;
    seed ^= seed << 5;
    return seed;
  endfunction : xs

  task automatic test_done();
    $display("compared %0d mismatches %0d", n_compared, num_errors);
    if (num_errors == 0 && n_compared > 0) begin
      $display("bench passed");
    end else begin
      $display("bench failed");
    end
    $finish;
  endtask : test_done

  task automatic chk(input string nm, input logic [31:0] e,
                     input logic [31:0] g);
    n_compared++;
    if (g !== e) begin
      num_errors++;
      $display("mismatch %s expected %h seen %h", nm, e, g);
    end
  endtask : chk

  // A transfer that never completes is a hang and ends the run.
  task automatic bus(input logic w, input logic [11:0] a, input logic [31:0] d);
    u_apb.xfer(w, a, d, rd, err, ok);
    if (!ok) begin
      num_errors++;
      $display("mismatch pready expected 1 seen 0");
      test_done();
    end
  endtask : bus

  task automatic rdc(input string nm, input logic [11:0] a,
                     input logic [31:0] e);
    bus(1'b0, a, 32'h0);
    chk(nm, e, rd);
  endtask : rdc

  task automatic wait_irq();
    for (i = 0; i < 3000; i++) begin
      @(posedge sys_clk);
      if (wake_irq === 1'b1) break;
    end
    if (wake_irq !== 1'b1) begin
      num_errors++;
      $display("mismatch wake_irq expected 1 seen 0");
      test_done();
    end
  endtask : wait_irq

  // ==========================================================================
  // Main sequence.
  initial begin
    repeat (4) @(posedge sys_clk);
    #1;
    rst_n = 1'b1;
    foreach (offs[j]) rdc("reset value", offs[j], rstv[j]);
    $display("test done: reset values");
    bus(1'b0, 12'h028, 32'h0);
    chk("unmapped error", 32'h1, {31'h0, err});
    chk("unmapped data", 32'h0, rd);
    bus(1'b1, 12'h004, 32'hF);
    rdc("read only status", 12'h004, 32'h2);
    $display("test done: address map");
    for (k = 0; k < 3; k++) begin
      m_div = 2 + int'(xs() % 4);
      bus(1'b1, `RCW_OFF_DIVISOR, m_div);
      bus(1'b1, `RCW_OFF_IRQ_EN, 32'h1);
      bus(1'b1, `RCW_OFF_CONTROL, 32'h3);
      bus(1'b1, `RCW_OFF_SLEEP, 32'h1 + (xs() % 4));
      wait_irq();
      rdc("raw", `RCW_OFF_RAW, 32'h1);
      rdc("enabled", `RCW_OFF_ENABLED, 32'h1);
      rdc("remaining", `RCW_OFF_REMAIN, 32'h0);
      rdc("go cleared", `RCW_OFF_CONTROL, 32'h3);
      bus(1'b1, `RCW_OFF_IRQ_EN, 32'h0);
      rdc("enabled off", `RCW_OFF_ENABLED, 32'h0);
      rdc("raw kept", `RCW_OFF_RAW, 32'h1);
      chk("wake_irq off", 32'h0, {31'h0, wake_irq});
      bus(1'b1, `RCW_OFF_CLEAR, 32'h1);
      rdc("raw cleared", `RCW_OFF_RAW, 32'h0);
    end
    $display("test done: countdown and interrupt");
    bus(1'b1, `RCW_OFF_CONTROL, 32'h1);
    bus(1'b1, `RCW_OFF_SLEEP, 32'h100);
    bus(1'b0, `RCW_OFF_STATUS, 32'h0);
    chk("manual idle", 32'h3, rd & ~32'h4);
    bus(1'b1, `RCW_OFF_CONTROL, 32'h5);
    bus(1'b0, `RCW_OFF_STATUS, 32'h0);
    chk("running", 32'hB, rd & ~32'h4);
    bus(1'b0, `RCW_OFF_REMAIN, 32'h0);
    chk("counting", 32'h1, {31'h0, rd != 0 && rd <= 32'h100});
    bus(1'b1, `RCW_OFF_CONTROL, 32'h1);
    bus(1'b0, `RCW_OFF_STATUS, 32'h0);
    chk("stopped", 32'h3, rd & ~32'h4);
    bus(1'b1, `RCW_OFF_CONTROL, 32'h0);
    rdc("disabled", `RCW_OFF_STATUS, 32'h2);
    $display("test done: manual start");
    r = xs() & 32'h0FFF_FFFF;
    bus(1'b1, `RCW_OFF_TICKS, r);
    repeat (40) @(posedge sys_clk);
    rdc("ticks held", `RCW_OFF_TICKS, r);
    bus(1'b1, `RCW_OFF_CONTROL, 32'h1);
    repeat (40) @(posedge sys_clk);
    bus(1'b0, `RCW_OFF_TICKS, 32'h0);
    chk("ticks advance", 32'h1, {31'h0, rd > r});
    $display("test done: tick counter");
    bus(1'b1, `RCW_OFF_SLEEP, 32'h5);
    rdc("pending", `RCW_OFF_ACCESS, 32'h0);
    for (k = 0; k < 50 && rd[0] !== 1'b1; k++) bus(1'b0, `RCW_OFF_ACCESS, 0);
    chk("accepting", 32'h1, rd);
    clk_gate = 1'b0;
    bus(1'b0, `RCW_OFF_ACCESS, 32'h0);
    bus(1'b0, `RCW_OFF_STATUS, 32'h0);
    chk("gate mirror", 32'h1, rd & ~32'h4);
    $display("test done: access status and gate");
    test_done();
  end
endmodule : rtc_countdown_wakeup_timer_test
